// [hdl/aux_pkg.sv]
// Behaviour
// - A control write with bit 3 set resets the whole processor.
// - Two 16-bit data pointers; bit 0 selects the one in use.
// - The unselected pointer is unreachable until the select bit toggles.
// - Pointer increment adds one to the selected pointer only.
// - Immediate load puts its 16-bit constant in the selected pointer.
// - Indirect jump target is accumulator plus selected pointer.
// - Code byte read uses selected pointer plus accumulator as address.
// - Data memory moves take their address from the selected pointer.
// - Pointer high and low byte accesses act on the selected pointer.
// - Bit 2 reads zero and ignores writes, so incrementing toggles select.
// - Keypad flag sets when an enabled port 0 pin goes low; software clears.
// - Brownout-off bit set turns brownout detection off.
// - Three signature bytes read by code byte read at FC30h, FC31h, FC60h.
// - 32-byte customer area readable by code byte read at FCE0h to FCFFh.
// - Data memory reads still reach the nonvolatile configuration bytes.
// - Both user configuration bytes readable by data memory move reads.
package aux_pkg;
  // register map
  localparam logic [7:0] AUX_ADDR = 8'ha2;
  localparam logic [7:0] PTR_LO_ADDR = 8'h82;
  localparam logic [7:0] PTR_HI_ADDR = 8'h83;
  localparam logic [7:0] AUX_RESET = 8'h00;
  // control register field positions
  localparam int KEYPAD_BIT = 7;
  localparam int BROWN_OFF_BIT = 6;
  localparam int BROWN_IRQ_BIT = 5;
  localparam int LOW_POWER_BIT = 4;
  localparam int SOFT_RST_BIT = 3;
  localparam int ZERO_BIT = 2;
  localparam int RSV_BIT = 1;
  localparam int PTR_SEL_BIT = 0;
  // code space special areas
  localparam logic [15:0] SIG0_ADDR = 16'hfc30;
  localparam logic [15:0] SIG1_ADDR = 16'hfc31;
  localparam logic [15:0] SIG2_ADDR = 16'hfc60;
  localparam logic [10:0] CUST_BASE = 11'h7e7; // fce0h >> 5
  // signature values: arbitrary, not any real part
  localparam logic [7:0] SIG0_VAL = 8'h5a;
  localparam logic [7:0] SIG1_VAL = 8'h3c;
  localparam logic [7:0] SIG2_VAL = 8'h96;
  // configuration byte addresses on the data memory path
  localparam logic [15:0] CFG1_ADDR = 16'hfd00;
  localparam logic [15:0] CFG2_ADDR = 16'hfd01;
  localparam logic [7:0] NO_DATA = 8'hff;
  // pointer operations issued by the core
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_INC = 3'b001,
    OP_LOAD = 3'b010,
    OP_JMP = 3'b011,
    OP_CREAD = 3'b100,
    OP_XRD = 3'b101,
    OP_XWR = 3'b110
  } op_e;
  // read path stage
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } stage_e;
endpackage

// [hdl/aux_control_dual_pointer.sv]
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module aux_control_dual_pointer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata_r,
  // pointer operations from the core
  input wire logic op_valid,
  input wire aux_pkg::op_e op,
  input wire logic [7:0] op_acc,
  input wire logic [15:0] op_imm,
  // code memory and accumulator return
  output logic code_req_r,
  output logic [15:0] code_addr_r,
  input wire logic [7:0] code_rdata,
  output logic acc_load_r,
  output logic [7:0] acc_byte_r,
  // jump and data memory write
  output logic jump_r,
  output logic [15:0] jump_target_r,
  output logic xmem_wr_r,
  output logic [15:0] xmem_addr_r,
  output logic [7:0] xmem_data_r,
  // keypad pins and configuration
  input wire logic [7:0] keypad_pin,
  input wire logic [7:0] keypad_enable,
  input wire logic [7:0] user_config_byte_one,
  input wire logic [7:0] user_config_byte_two,
  // customer area load from programming logic
  input wire logic prog_we,
  input wire logic [4:0] prog_addr,
  input wire logic [7:0] prog_data,
  // control outputs
  output logic chip_reset_r,
  output logic pointer_select_r,
  output logic brownout_off_r,
  output logic brownout_irq_mode_r,
  output logic low_power_eprom_r
);

  typedef struct packed {
    logic keypad_flag;
    logic brownout_off;
    logic brownout_irq_mode;
    logic low_power_eprom;
    logic pointer_select;
    logic [1:0][15:0] data_pointer;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic kb_low;
    logic [7:0] rdata;
    logic chip_reset;
    aux_pkg::stage_e stage;
    logic is_code;
    logic [15:0] addr;
    logic code_req;
    logic [7:0] acc_byte;
    logic acc_load;
    logic jump;
    logic xwr;
    logic [7:0] xdata;
    logic [31:0][7:0] cust;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic [15:0] cur_ptr;
  logic [15:0] ea;
  logic kb_now;
  logic soft_rst;
  logic [7:0] aux_view;

  // the selected pointer is the only one any path sees
  assign cur_ptr = s_r.data_pointer[s_r.pointer_select];
  assign ea = cur_ptr + {8'h00, op_acc};
  assign kb_now = |(~s_r.pin_s2 & keypad_enable);
  assign soft_rst = sfr_wr && sfr_addr == aux_pkg::AUX_ADDR &&
                    sfr_wdata[aux_pkg::SOFT_RST_BIT];

  // read view: reset bit, bit 2 and reserved bit 1 read zero
  always_comb begin
    aux_view = 8'h00;
    aux_view[aux_pkg::KEYPAD_BIT] = s_r.keypad_flag;
    aux_view[aux_pkg::BROWN_OFF_BIT] = s_r.brownout_off;
    aux_view[aux_pkg::BROWN_IRQ_BIT] = s_r.brownout_irq_mode;
    aux_view[aux_pkg::LOW_POWER_BIT] = s_r.low_power_eprom;
    aux_view[aux_pkg::PTR_SEL_BIT] = s_r.pointer_select;
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    s_nxt.chip_reset = 1'b0;
    s_nxt.code_req = 1'b0;
    s_nxt.acc_load = 1'b0;
    s_nxt.jump = 1'b0;
    s_nxt.xwr = 1'b0;
    // two-flop sync of the port 0 pins before anything looks at them
    s_nxt.pin_s1 = keypad_pin;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.kb_low = kb_now;

    // register reads, answered next cycle; unmapped reads zero
    if (sfr_rd) begin
      unique case (sfr_addr)
        aux_pkg::AUX_ADDR: s_nxt.rdata = aux_view;
        aux_pkg::PTR_LO_ADDR: s_nxt.rdata = cur_ptr[7:0];
        aux_pkg::PTR_HI_ADDR: s_nxt.rdata = cur_ptr[15:8];
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // register writes; bits 3..1 are not stored
    if (sfr_wr) begin
      unique case (sfr_addr)
        aux_pkg::AUX_ADDR: begin
          s_nxt.keypad_flag = sfr_wdata[aux_pkg::KEYPAD_BIT];
          s_nxt.brownout_off = sfr_wdata[aux_pkg::BROWN_OFF_BIT];
          s_nxt.brownout_irq_mode = sfr_wdata[aux_pkg::BROWN_IRQ_BIT];
          // low power bit only sets from software; reset clears it
          s_nxt.low_power_eprom = s_r.low_power_eprom |
                                  sfr_wdata[aux_pkg::LOW_POWER_BIT];
          s_nxt.pointer_select = sfr_wdata[aux_pkg::PTR_SEL_BIT];
        end
        aux_pkg::PTR_LO_ADDR: begin
          s_nxt.data_pointer[s_r.pointer_select][7:0] = sfr_wdata;
        end
        aux_pkg::PTR_HI_ADDR: begin
          s_nxt.data_pointer[s_r.pointer_select][15:8] = sfr_wdata;
        end
        default: begin
        end
      endcase
    end

    // a falling enabled pin sets the flag; set beats a same-cycle clear
    if (kb_now && !s_r.kb_low) begin
      s_nxt.keypad_flag = 1'b1;
    end

    // pointer operations; address users are refused while a read is busy
    if (op_valid) begin
      unique case (op)
        aux_pkg::OP_INC: begin
          s_nxt.data_pointer[s_r.pointer_select] = cur_ptr + 16'h0001;
        end
        aux_pkg::OP_LOAD: begin
          s_nxt.data_pointer[s_r.pointer_select] = op_imm;
        end
        aux_pkg::OP_JMP: begin
          if (s_r.stage == aux_pkg::ST_IDLE) begin
            s_nxt.jump = 1'b1;
            s_nxt.addr = ea;
          end
        end
        aux_pkg::OP_CREAD: begin
          if (s_r.stage == aux_pkg::ST_IDLE) begin
            s_nxt.code_req = 1'b1;
            s_nxt.addr = ea;
            s_nxt.is_code = 1'b1;
            s_nxt.stage = aux_pkg::ST_ADDR;
          end
        end
        aux_pkg::OP_XRD: begin
          if (s_r.stage == aux_pkg::ST_IDLE) begin
            s_nxt.addr = cur_ptr;
            s_nxt.is_code = 1'b0;
            s_nxt.stage = aux_pkg::ST_ADDR;
          end
        end
        aux_pkg::OP_XWR: begin
          if (s_r.stage == aux_pkg::ST_IDLE) begin
            s_nxt.xwr = 1'b1;
            s_nxt.addr = cur_ptr;
            s_nxt.xdata = op_acc;
          end
        end
        default: begin
        end
      endcase
    end

    // read path: code memory answers the cycle after the request
    unique case (s_r.stage)
      aux_pkg::ST_ADDR: s_nxt.stage = aux_pkg::ST_DATA;
      aux_pkg::ST_DATA: begin
        s_nxt.stage = aux_pkg::ST_IDLE;
        s_nxt.acc_load = 1'b1;
        if (s_r.is_code) begin
          // signature and customer bytes shadow code memory
          if (s_r.addr == aux_pkg::SIG0_ADDR) begin
            s_nxt.acc_byte = aux_pkg::SIG0_VAL;
          end else if (s_r.addr == aux_pkg::SIG1_ADDR) begin
            s_nxt.acc_byte = aux_pkg::SIG1_VAL;
          end else if (s_r.addr == aux_pkg::SIG2_ADDR) begin
            s_nxt.acc_byte = aux_pkg::SIG2_VAL;
          end else if (s_r.addr[15:5] == aux_pkg::CUST_BASE) begin
            s_nxt.acc_byte = s_r.cust[s_r.addr[4:0]];
          end else begin
            s_nxt.acc_byte = code_rdata;
          end
        end else begin
          // no external bus: only the configuration bytes answer
          if (s_r.addr == aux_pkg::CFG1_ADDR) begin
            s_nxt.acc_byte = user_config_byte_one;
          end else if (s_r.addr == aux_pkg::CFG2_ADDR) begin
            s_nxt.acc_byte = user_config_byte_two;
          end else begin
            s_nxt.acc_byte = aux_pkg::NO_DATA;
          end
        end
      end
      default: begin
      end
    endcase

    // any reset restores everything but the nonvolatile customer bytes
    if (rst || soft_rst) begin
      s_nxt = '0;
      s_nxt.cust = s_r.cust;
      // pins idle high; a zeroed sync would fake a falling edge
      s_nxt.pin_s1 = 8'hff;
      s_nxt.pin_s2 = 8'hff;
      s_nxt.chip_reset = soft_rst && !rst;
    end

    // programming logic loads the customer area, even in a reset cycle
    if (prog_we) begin
      s_nxt.cust[prog_addr] = prog_data;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // all outputs straight from the state register
  assign sfr_rdata_r = s_r.rdata;
  assign code_req_r = s_r.code_req;
  assign code_addr_r = s_r.addr;
  assign acc_load_r = s_r.acc_load;
  assign acc_byte_r = s_r.acc_byte;
  assign jump_r = s_r.jump;
  assign jump_target_r = s_r.addr;
  assign xmem_wr_r = s_r.xwr;
  assign xmem_addr_r = s_r.addr;
  assign xmem_data_r = s_r.xdata;
  assign chip_reset_r = s_r.chip_reset;
  assign pointer_select_r = s_r.pointer_select;
  assign brownout_off_r = s_r.brownout_off;
  assign brownout_irq_mode_r = s_r.brownout_irq_mode;
  assign low_power_eprom_r = s_r.low_power_eprom;

  // software reset pulses once and clears select and pointers
  soft_reset_a: assert property (@(posedge clk) disable iff (rst)
    soft_rst |=> chip_reset_r && !pointer_select_r &&
    s_r.data_pointer == '0 ##1 !chip_reset_r)
    else $error("software reset did not clear state");

  // increment touches only the selected pointer
  ptr_inc_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == aux_pkg::OP_INC && !sfr_wr |=>
    s_r.data_pointer[$past(s_r.pointer_select)] ==
    $past(cur_ptr) + 16'h0001 &&
    s_r.data_pointer[!$past(s_r.pointer_select)] ==
    $past(s_r.data_pointer[!s_r.pointer_select]))
    else $error("pointer increment wrong");

  // immediate load lands in the selected pointer
  ptr_load_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == aux_pkg::OP_LOAD && !sfr_wr |=>
    s_r.data_pointer[s_r.pointer_select] == $past(op_imm))
    else $error("pointer load wrong");

  // jump target formed from the selected pointer
  jump_target_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == aux_pkg::OP_JMP && s_r.stage == aux_pkg::ST_IDLE
    && !soft_rst |=> jump_r && jump_target_r == $past(ea))
    else $error("jump target wrong");

  // code read: address next cycle, accumulator load two cycles later
  code_read_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == aux_pkg::OP_CREAD && s_r.stage == aux_pkg::ST_IDLE
    && !soft_rst |=> code_req_r && code_addr_r == $past(ea)
    ##1 !acc_load_r ##1 acc_load_r)
    else $error("code byte read sequence wrong");

  // signature byte returned three cycles after the request
  sig_read_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == aux_pkg::OP_CREAD && s_r.stage == aux_pkg::ST_IDLE
    && ea == aux_pkg::SIG0_ADDR && !soft_rst ##1 !soft_rst[*2] |=>
    acc_load_r && acc_byte_r == aux_pkg::SIG0_VAL)
    else $error("signature byte wrong");

  // bit 2 and the reset bit never read back as one
  zero_bit_a: assert property (@(posedge clk) disable iff (rst)
    sfr_rd && sfr_addr == aux_pkg::AUX_ADDR |=>
    !sfr_rdata_r[aux_pkg::ZERO_BIT] && !sfr_rdata_r[aux_pkg::SOFT_RST_BIT])
    else $error("hard-wired zero bit read as one");

  // low byte read follows the selected pointer
  low_read_a: assert property (@(posedge clk) disable iff (rst)
    sfr_rd && sfr_addr == aux_pkg::PTR_LO_ADDR |=>
    sfr_rdata_r == $past(cur_ptr[7:0]))
    else $error("low byte read from wrong pointer");

  // an enabled pin falling sets the flag even against a clear
  keypad_set_a: assert property (@(posedge clk) disable iff (rst)
    kb_now && !s_r.kb_low && !soft_rst |=> s_r.keypad_flag)
    else $error("keypad flag not set");

  // brownout-off output follows the written bit
  brownout_off_a: assert property (@(posedge clk) disable iff (rst)
    sfr_wr && sfr_addr == aux_pkg::AUX_ADDR && !soft_rst |=>
    brownout_off_r == $past(sfr_wdata[aux_pkg::BROWN_OFF_BIT]))
    else $error("brownout off bit not applied");

  // a control write moves the select bit to the written value
  select_write_a: assert property (@(posedge clk) disable iff (rst)
    sfr_wr && sfr_addr == aux_pkg::AUX_ADDR && !soft_rst |=>
    pointer_select_r == $past(sfr_wdata[aux_pkg::PTR_SEL_BIT]))
    else $error("pointer select not applied");

  // data write carries the selected pointer and the accumulator
  data_write_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == aux_pkg::OP_XWR && s_r.stage == aux_pkg::ST_IDLE
    && !soft_rst |=> xmem_wr_r && xmem_addr_r == $past(cur_ptr) &&
    xmem_data_r == $past(op_acc))
    else $error("data write address wrong");

  // no external bus, but the first configuration byte still answers
  config_read_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == aux_pkg::OP_XRD && s_r.stage == aux_pkg::ST_IDLE
    && cur_ptr == aux_pkg::CFG1_ADDR && !soft_rst ##1 !soft_rst[*2] |=>
    acc_load_r && acc_byte_r == user_config_byte_one)
    else $error("configuration byte read wrong");

  // hardware reset leaves the register and both pointers at zero
  reset_clear_a: assert property (@(posedge clk)
    rst |=> aux_view == aux_pkg::AUX_RESET && s_r.data_pointer == '0)
    else $error("reset did not clear the register");

endmodule
`default_nettype wire

// [dv/aux_control_dual_pointer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module aux_control_dual_pointer_tb;
  logic clk, rst, sfr_wr, sfr_rd, op_valid, prog_we;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_r, op_acc, code_rdata;
  logic [7:0] keypad_pin, keypad_enable, prog_data, acc_byte_r;
  logic [7:0] user_config_byte_one, user_config_byte_two, xmem_data_r;
  logic [15:0] op_imm, code_addr_r, jump_target_r, xmem_addr_r;
  logic [4:0] prog_addr;
  aux_pkg::op_e op;
  logic code_req_r, acc_load_r, jump_r, xmem_wr_r, chip_reset_r;
  logic pointer_select_r, brownout_off_r, brownout_irq_mode_r;
  logic low_power_eprom_r;
  int mismatches, compares;
  logic [31:0] seed = 32'h6caa;
  // reference model of the register and both pointers
  logic [7:0] aux, r8;
  logic [15:0] ptr [2];
  logic [7:0] cust [32];
  logic [15:0] alist [6];

  aux_control_dual_pointer u_aux_control_dual_pointer (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_r(sfr_rdata_r),
    .op_valid(op_valid), .op(op), .op_acc(op_acc), .op_imm(op_imm),
    .code_req_r(code_req_r), .code_addr_r(code_addr_r),
    .code_rdata(code_rdata), .acc_load_r(acc_load_r),
    .acc_byte_r(acc_byte_r), .jump_r(jump_r), .jump_target_r(jump_target_r),
    .xmem_wr_r(xmem_wr_r), .xmem_addr_r(xmem_addr_r),
    .xmem_data_r(xmem_data_r), .keypad_pin(keypad_pin),
    .keypad_enable(keypad_enable),
    .user_config_byte_one(user_config_byte_one),
    .user_config_byte_two(user_config_byte_two), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_data(prog_data),
    .chip_reset_r(chip_reset_r), .pointer_select_r(pointer_select_r),
    .brownout_off_r(brownout_off_r),
    .brownout_irq_mode_r(brownout_irq_mode_r),
    .low_power_eprom_r(low_power_eprom_r)
  );

  // free running bench clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // xorshift source, fixed seed so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // byte the core should see for a code read at this address
  function automatic logic [7:0] cexp(input logic [15:0] ad,
                                      input logic [7:0] raw);
    if (ad == aux_pkg::SIG0_ADDR) return aux_pkg::SIG0_VAL;
    if (ad == aux_pkg::SIG1_ADDR) return aux_pkg::SIG1_VAL;
    if (ad == aux_pkg::SIG2_ADDR) return aux_pkg::SIG2_VAL;
    if (ad[15:5] == aux_pkg::CUST_BASE) return cust[ad[4:0]];
    return raw;
  endfunction

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  // one-cycle write; model follows the register's storage rules
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1;
    if (a == aux_pkg::AUX_ADDR && d[3]) begin
      aux = 8'h00;
      ptr[0] = 16'h0000;
      ptr[1] = 16'h0000;
    end else if (a == aux_pkg::AUX_ADDR) begin
      aux = {d[7:5], aux[4] | d[4], 3'b000, d[0]};
    end else if (a == aux_pkg::PTR_LO_ADDR) begin
      ptr[aux[0]][7:0] = d;
    end else if (a == aux_pkg::PTR_HI_ADDR) begin
      ptr[aux[0]][15:8] = d;
    end
  endtask

  // one-cycle read, data looked at in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    `CHK("sfr read", e, sfr_rdata_r)
  endtask

  // pointer operation; reads are spaced by the wait for their answer
  task automatic po(input aux_pkg::op_e o, input logic [7:0] a,
                    input logic [15:0] imm);
    logic [15:0] t;
    logic [7:0] raw;
    raw = 8'(rnd());
    t = ptr[aux[0]] + {8'h00, a};
    @(posedge clk);
    op_valid <= 1'b1;
    op <= o;
    op_acc <= a;
    op_imm <= imm;
    code_rdata <= raw;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    case (o)
      aux_pkg::OP_LOAD: ptr[aux[0]] = imm;
      aux_pkg::OP_INC: ptr[aux[0]] = ptr[aux[0]] + 16'h0001;
      aux_pkg::OP_JMP: `CHK("jump", {1'b1, t}, {jump_r, jump_target_r})
      aux_pkg::OP_XWR: begin
        `CHK("xwr", 1'b1, xmem_wr_r)
        `CHK("xwr addr", ptr[aux[0]], xmem_addr_r)
        `CHK("xwr data", a, xmem_data_r)
      end
      aux_pkg::OP_CREAD: begin
        `CHK("fetch", {1'b1, t}, {code_req_r, code_addr_r})
        repeat (2) @(posedge clk);
        #1;
        `CHK("acc load", 1'b1, acc_load_r)
        `CHK("code byte", cexp(t, raw), acc_byte_r)
      end
      default: begin
        repeat (2) @(posedge clk);
        #1;
        t = ptr[aux[0]];
        raw = (t == aux_pkg::CFG1_ADDR) ? user_config_byte_one :
              (t == aux_pkg::CFG2_ADDR) ? user_config_byte_two :
              aux_pkg::NO_DATA;
        `CHK("xrd", {1'b1, raw}, {acc_load_r, acc_byte_r})
      end
    endcase
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    {rst, sfr_wr, sfr_rd, op_valid, prog_we} = 5'b10000;
    {sfr_addr, sfr_wdata, op_acc, prog_data, keypad_enable} = 40'h0;
    {op_imm, prog_addr, keypad_pin} = {16'h0000, 5'h00, 8'hff};
    op = aux_pkg::OP_NONE;
    code_rdata = 8'h00;
    user_config_byte_one = 8'(rnd());
    user_config_byte_two = 8'(rnd());
    aux = 8'h00;
    ptr[0] = 16'h0000;
    ptr[1] = 16'h0000;
    alist = '{aux_pkg::SIG0_ADDR, aux_pkg::SIG1_ADDR, aux_pkg::SIG2_ADDR,
              16'hfce0, 16'hfcff, 16'h0123};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // fill the customer area back to back
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      cust[i] = 8'(rnd());
      prog_we <= 1'b1;
      prog_addr <= i[4:0];
      prog_data <= cust[i];
    end
    @(posedge clk);
    prog_we <= 1'b0;
    rd(aux_pkg::AUX_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    note("reset");
    // bit 2 written high must not stick; low power bit only sets
    wr(aux_pkg::AUX_ADDR, 8'hf4);
    rd(aux_pkg::AUX_ADDR, aux);
    `CHK("brownout off", aux[6], brownout_off_r)
    `CHK("brownout irq", aux[5], brownout_irq_mode_r)
    `CHK("low power", aux[4], low_power_eprom_r)
    wr(aux_pkg::AUX_ADDR, 8'h00);
    rd(aux_pkg::AUX_ADDR, aux);
    note("control bits");
    // load each pointer under its own select, read the bytes back
    for (int s = 0; s < 2; s++) begin
      wr(aux_pkg::AUX_ADDR, {aux[7:1], s[0]});
      `CHK("select", s[0], pointer_select_r)
      po(aux_pkg::OP_LOAD, 8'h00, 16'(rnd()));
      rd(aux_pkg::PTR_LO_ADDR, ptr[s][7:0]);
      rd(aux_pkg::PTR_HI_ADDR, ptr[s][15:8]);
    end
    // increment with a carry into the high byte, then a low byte write
    po(aux_pkg::OP_LOAD, 8'h00, 16'h12ff);
    po(aux_pkg::OP_INC, 8'h00, 16'h0000);
    rd(aux_pkg::PTR_HI_ADDR, ptr[1][15:8]);
    r8 = 8'(rnd());
    wr(aux_pkg::PTR_LO_ADDR, r8);
    rd(aux_pkg::PTR_LO_ADDR, ptr[1][7:0]);
    // increment the register value to switch back; other pointer untouched
    wr(aux_pkg::AUX_ADDR, aux + 8'h01);
    rd(aux_pkg::AUX_ADDR, aux);
    rd(aux_pkg::PTR_LO_ADDR, ptr[0][7:0]);
    rd(aux_pkg::PTR_HI_ADDR, ptr[0][15:8]);
    note("pointers");
    // jumps stay clear of the customer area
    po(aux_pkg::OP_LOAD, 8'h00, 16'h0100);
    po(aux_pkg::OP_JMP, 8'(rnd()), 16'h0000);
    po(aux_pkg::OP_XWR, 8'(rnd()), 16'h0000);
    // signature, customer area edges and ordinary code
    foreach (alist[i]) begin
      r8 = 8'(rnd());
      po(aux_pkg::OP_LOAD, 8'h00, alist[i] - {8'h00, r8});
      po(aux_pkg::OP_CREAD, r8, 16'h0000);
    end
    po(aux_pkg::OP_LOAD, 8'h00, aux_pkg::CFG1_ADDR);
    po(aux_pkg::OP_XRD, 8'h00, 16'h0000);
    po(aux_pkg::OP_INC, 8'h00, 16'h0000);
    po(aux_pkg::OP_XRD, 8'h00, 16'h0000);
    po(aux_pkg::OP_INC, 8'h00, 16'h0000);
    po(aux_pkg::OP_XRD, 8'h00, 16'h0000);
    note("address ops");
    // a disabled pin falling leaves the flag alone
    @(posedge clk);
    keypad_enable <= 8'h04;
    keypad_pin <= 8'hfe;
    repeat (5) @(posedge clk);
    rd(aux_pkg::AUX_ADDR, aux);
    @(posedge clk);
    keypad_pin <= 8'hfa;
    repeat (5) @(posedge clk);
    aux[7] = 1'b1;
    keypad_pin <= 8'hff;
    repeat (5) @(posedge clk);
    rd(aux_pkg::AUX_ADDR, aux);
    wr(aux_pkg::AUX_ADDR, aux & 8'h7f);
    rd(aux_pkg::AUX_ADDR, aux);
    note("keypad");
    // software reset clears register, selected pointer high byte and low power bit
    wr(aux_pkg::AUX_ADDR, 8'h10);
    po(aux_pkg::OP_LOAD, 8'h00, 16'hbeef);
    wr(aux_pkg::AUX_ADDR, 8'h39);
    #1;
    `CHK("soft reset", 1'b1, chip_reset_r)
    rd(aux_pkg::AUX_ADDR, 8'h00);
    rd(aux_pkg::PTR_HI_ADDR, 8'h00);
    `CHK("low_power_eprom", 1'b0, low_power_eprom_r)
    note("software reset");
    test_done();
  end
endmodule
`default_nettype wire
